//--- hdl/srs_fetch.sv
`timescale 1ns/1ns
`include "srs_defines.svh"
// prefetches bytes from the array, one request outstanding at a time
module srs_fetch #(
  parameter int AW = `SRS_ADDR_W
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          flush_in,
  input  wire logic [AW-1:0] start_addr_in,
  output logic      [AW-1:0] mem_addr_out,
  output logic               mem_rd_out,
  input  wire logic [7:0]    mem_data_in,
  input  wire logic          mem_valid_in,
  srs_byte_if.prod           out
);
  logic [AW-1:0] ptr_r;
  logic          pend_r;
  logic          drop_r;
  logic          hold_r;
  logic [7:0]    data_r;

  assign out.valid = hold_r;
  assign out.data  = data_r;

  // request / answer tracking; an answer to a flushed request is dropped
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ptr_r        <= `SRS_ADDR_RESET;
      pend_r       <= 1'b0;
      drop_r       <= 1'b0;
      hold_r       <= 1'b0;
      data_r       <= `SRS_EMPTY_BYTE;
      mem_addr_out <= `SRS_ADDR_RESET;
      mem_rd_out   <= 1'b0;
    end else begin
      mem_rd_out <= 1'b0;
      if (hold_r && out.ready) begin
        hold_r <= 1'b0;
      end
      if (flush_in) begin
        ptr_r  <= start_addr_in;
        hold_r <= 1'b0;
        pend_r <= 1'b0;
        drop_r <= (pend_r | drop_r) & ~mem_valid_in;  // an older answer may still be due
      end else if (mem_valid_in && drop_r) begin
        drop_r <= 1'b0;
      end else if (mem_valid_in && pend_r) begin
        data_r <= mem_data_in;
        hold_r <= 1'b1;
        pend_r <= 1'b0;
        ptr_r  <= ptr_r + 1'b1;                 // wraps at the top
      end else if (!pend_r && !drop_r && !hold_r) begin
        mem_addr_out <= ptr_r;
        mem_rd_out   <= 1'b1;
        pend_r       <= 1'b1;
      end
    end
  end
endmodule

//--- hdl/srs_fifo.sv
`timescale 1ns/1ns
// small synchronous fifo; flush empties it in one cycle
module srs_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic flush_in,
  srs_byte_if.cons  wr,
  srs_byte_if.prod  rd
);
  localparam int PW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [PW:0]  wp_r;
  logic [PW:0]  rp_r;
  logic         push;
  logic         pop;

  // extra pointer bit tells full from empty
  assign wr.ready = (wp_r - rp_r) != (PW+1)'(D);
  assign rd.valid = wp_r != rp_r;
  assign rd.data  = mem_r[rp_r[PW-1:0]];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  // pointers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || flush_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wp_r[PW-1:0]] <= wr.data;
    end
  end
endmodule

//--- hdl/srs_read_seq.sv
`timescale 1ns/1ns
`include "srs_defines.svh"
module srs_read_seq #(
  parameter int AW        = `SRS_ADDR_W,
  parameter int WR_CYCLES = `SRS_WR_CYCLES
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe_out,
  input  wire logic          chip_select_strap_in,
  output logic [AW-1:0]      mem_addr_out,
  output logic               mem_rd_out,
  input  wire logic [7:0]    mem_data_in,
  input  wire logic          mem_valid_in,
  input  wire logic          addr_set_in,
  input  wire logic [AW-1:0] addr_set_val_in,
  input  wire logic          write_stop_in,
  output logic               busy_out
);
  srs_pkg::srs_state_e state_r;
  logic [`SRS_BIT_CNT_W-1:0] cnt_r;
  srs_pkg::srs_byte_t  sh_r;
  srs_pkg::srs_byte_t  tx_r;
  logic [1:0]          page_r;
  logic                rw_r;
  logic                mack_r;
  logic                scl_q;
  logic                sda_q;
  logic                strap_r;
  logic [AW-1:0]       addr_r;
  logic                flush_r;
  logic [`SRS_WR_CNT_W-1:0] wr_cnt_r;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  logic                quiet;
  logic                byte_end;
  logic                load;
  logic                pop_ok;
  logic                waddr_done;
  srs_pkg::srs_byte_t  next_byte;

  srs_byte_if #(.W(`SRS_DATA_W)) fetch_q ();
  srs_byte_if #(.W(`SRS_DATA_W)) rd ();

  // address byte compare against type code and strap
  function automatic logic addr_match(input srs_pkg::srs_byte_t b, input logic strap);
    addr_match = (b[`SRS_TYPE_MSB:`SRS_TYPE_LSB] == `SRS_TYPE_CODE) && (b[`SRS_STRAP_BIT] == strap);
  endfunction

  // prefetch keeps the fifo topped up so a byte is ready at each ack
  srs_fetch #(.AW(AW)) u_fetch (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .flush_in      (flush_r),
    .start_addr_in (addr_r),
    .mem_addr_out  (mem_addr_out),
    .mem_rd_out    (mem_rd_out),
    .mem_data_in   (mem_data_in),
    .mem_valid_in  (mem_valid_in),
    .out           (fetch_q.prod)
  );

  srs_fifo #(.W(`SRS_DATA_W), .D(`SRS_FIFO_DEPTH)) u_fifo (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .flush_in (flush_r),
    .wr       (fetch_q.cons),
    .rd       (rd.prod)
  );

  // bus conditions; inputs are already synchronous, one stage for edges
  assign scl_rise  = scl_in & ~scl_q;
  assign scl_fall  = ~scl_in & scl_q;
  assign start_det = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_det  = scl_in & scl_q & ~sda_q & sda_in;
  assign quiet     = ~start_det & ~stop_det;
  assign byte_end  = scl_fall & (cnt_r == `SRS_BITS_PER_BYTE) & quiet;

  // a byte is loaded at the fall that ends a read's device ack slot or a master ack slot
  assign load       = scl_fall & quiet &
                      (((state_r == srs_pkg::SRS_DEV_ACK) & rw_r) |
                       ((state_r == srs_pkg::SRS_TX_ACK) & mack_r));
  assign pop_ok     = load & rd.valid;
  assign rd.ready   = load;
  // an empty fifo means the master clocked faster than the array answered
  assign next_byte  = rd.valid ? rd.data : `SRS_EMPTY_BYTE;
  assign waddr_done = (state_r == srs_pkg::SRS_WADDR) & byte_end;

  // edge history of both bus lines
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // strap follows the pin after reset, not captured under reset
  always_ff @(posedge clk_in) begin
    strap_r <= chip_select_strap_in;
  end

  // open drain: the level is always low, only the enable moves
  always_ff @(posedge clk_in) begin
    sda_out <= 1'b0;
  end

  // write cycle timer, busy until it runs out
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_cnt_r <= '0;
      busy_out <= 1'b0;
    end else if (write_stop_in) begin
      wr_cnt_r <= `SRS_WR_CNT_W'(WR_CYCLES);
      busy_out <= 1'b1;
    end else if (wr_cnt_r != '0) begin
      wr_cnt_r <= wr_cnt_r - 1'b1;
      busy_out <= (wr_cnt_r != `SRS_WR_CNT_W'(1));
    end
  end

  // word address counter, shared with the write side
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      addr_r  <= `SRS_ADDR_RESET;
      flush_r <= 1'b0;
    end else begin
      flush_r <= 1'b0;
      if (addr_set_in) begin
        addr_r  <= addr_set_val_in;
        flush_r <= 1'b1;
      end else if (waddr_done) begin
        addr_r  <= {page_r, sh_r};
        flush_r <= 1'b1;
      end else if (pop_ok) begin
        addr_r <= addr_r + 1'b1;
      end
    end
  end

  // bus sequencer: receive, acknowledge, transmit
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r    <= srs_pkg::SRS_IDLE;
      cnt_r      <= '0;
      sh_r       <= '0;
      tx_r       <= `SRS_EMPTY_BYTE;
      page_r     <= '0;
      rw_r       <= 1'b0;
      mack_r     <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (stop_det) begin
      state_r    <= srs_pkg::SRS_IDLE;
      sda_oe_out <= 1'b0;
    end else if (start_det) begin
      state_r    <= srs_pkg::SRS_DEV;
      cnt_r      <= '0;
      sda_oe_out <= 1'b0;
    end else begin
      case (state_r)
        srs_pkg::SRS_DEV, srs_pkg::SRS_WADDR: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_in};
            cnt_r <= cnt_r + 1'b1;
          end else if (byte_end) begin
            cnt_r <= '0;
            if (state_r == srs_pkg::SRS_WADDR) begin
              sda_oe_out <= 1'b1;
              state_r    <= srs_pkg::SRS_WADDR_ACK;
            end else if (addr_match(sh_r, strap_r) && !busy_out) begin
              sda_oe_out <= 1'b1;
              rw_r       <= sh_r[`SRS_RW_BIT];
              page_r     <= sh_r[`SRS_PAGE_MSB:`SRS_PAGE_LSB];
              state_r    <= srs_pkg::SRS_DEV_ACK;
            end else begin
              state_r <= srs_pkg::SRS_WAIT;
            end
          end
        end
        srs_pkg::SRS_DEV_ACK: begin
          if (load) begin
            tx_r       <= next_byte;
            sda_oe_out <= ~next_byte[7];
            cnt_r      <= `SRS_FIRST_TX_CNT;
            state_r    <= srs_pkg::SRS_TX;
          end else if (scl_fall) begin
            sda_oe_out <= 1'b0;
            state_r    <= srs_pkg::SRS_WADDR;
          end
        end
        srs_pkg::SRS_WADDR_ACK: begin
          // data bytes of a write belong to the write side
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            state_r    <= srs_pkg::SRS_WAIT;
          end
        end
        srs_pkg::SRS_TX: begin
          if (scl_fall) begin
            if (cnt_r == `SRS_BITS_PER_BYTE) begin
              sda_oe_out <= 1'b0;
              state_r    <= srs_pkg::SRS_TX_ACK;
            end else begin
              sda_oe_out <= ~tx_r[6];
              tx_r       <= {tx_r[6:0], 1'b1};
              cnt_r      <= cnt_r + 1'b1;
            end
          end
        end
        srs_pkg::SRS_TX_ACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_in;
          end else if (load) begin
            tx_r       <= next_byte;
            sda_oe_out <= ~next_byte[7];
            cnt_r      <= `SRS_FIRST_TX_CNT;
            state_r    <= srs_pkg::SRS_TX;
          end else if (scl_fall) begin
            state_r <= srs_pkg::SRS_WAIT;
          end
        end
        srs_pkg::SRS_IDLE, srs_pkg::SRS_WAIT: begin
          sda_oe_out <= 1'b0;
        end
        default: begin
          state_r    <= srs_pkg::SRS_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // checks of the bus sequencer
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_ack_match;
    (state_r == srs_pkg::SRS_DEV) && byte_end && addr_match(sh_r, strap_r) && !busy_out
      |=> (state_r == srs_pkg::SRS_DEV_ACK) && sda_oe_out;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("matching address not acked");

  property p_nack_mismatch;
    (state_r == srs_pkg::SRS_DEV) && byte_end && !addr_match(sh_r, strap_r)
      |=> (state_r == srs_pkg::SRS_WAIT) ##1 !sda_oe_out;
  endproperty
  a_nack_mismatch: assert property (p_nack_mismatch) else $error("foreign address acked");

  property p_busy_ignore;
    busy_out && (state_r == srs_pkg::SRS_DEV) && byte_end |=> !sda_oe_out [*2];
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("acked while write cycle runs");

  property p_busy_start;
    write_stop_in |=> busy_out;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("write cycle not started");

  property p_waddr_load;
    waddr_done && !addr_set_in |=> (addr_r == {$past(page_r), $past(sh_r)}) && flush_r;
  endproperty
  a_waddr_load: assert property (p_waddr_load) else $error("word address not loaded");

  property p_addr_inc;
    pop_ok && !addr_set_in |=> addr_r == AW'($past(addr_r) + 1'b1);
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("word address not advanced");

  property p_addr_wrap;
    pop_ok && !addr_set_in && (addr_r == '1) |=> addr_r == `SRS_ADDR_RESET;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("word address did not wrap");

  property p_first_bit;
    load && rd.valid |=> (state_r == srs_pkg::SRS_TX) && (sda_oe_out == ~$past(rd.data[7]));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first data bit wrong");

  property p_ack_release;
    (state_r == srs_pkg::SRS_WADDR_ACK) && scl_fall && quiet |=> !sda_oe_out;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack held past ninth clock");

  property p_nack_end;
    (state_r == srs_pkg::SRS_TX_ACK) && scl_fall && quiet && !mack_r
      |=> (state_r == srs_pkg::SRS_WAIT) && !sda_oe_out;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("read not ended on no-ack");

  property p_stop_idle;
    stop_det |=> (state_r == srs_pkg::SRS_IDLE) && !sda_oe_out;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("line held after stop");

  c_random_read: cover property (waddr_done ##[1:1000] (load && rw_r));
  c_seq_read:    cover property ((state_r == srs_pkg::SRS_TX_ACK) && load);
  c_wrap:        cover property (pop_ok && (addr_r == '1));
  c_busy_nack:   cover property (busy_out && (state_r == srs_pkg::SRS_DEV) && byte_end);
endmodule

//--- pkg/srs_byte_if.sv
`timescale 1ns/1ns
// byte stream with valid/ready handshake between internal stages
interface srs_byte_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport prod (output valid, output data, input ready);
  modport cons (input valid, input data, output ready);
endinterface

//--- pkg/srs_defines.svh
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

// device address byte layout
`define SRS_TYPE_CODE      4'hA
`define SRS_TYPE_MSB       7
`define SRS_TYPE_LSB       4
`define SRS_STRAP_BIT      3
`define SRS_PAGE_MSB       2
`define SRS_PAGE_LSB       1
`define SRS_RW_BIT         0

// word address and byte framing
`define SRS_ADDR_W         10
`define SRS_DATA_W         8
`define SRS_BIT_CNT_W      4
`define SRS_BITS_PER_BYTE  4'h8
`define SRS_FIRST_TX_CNT   4'h1
`define SRS_ADDR_RESET     10'h000
`define SRS_EMPTY_BYTE     8'hFF

// buffering
`define SRS_FIFO_DEPTH     4

// write cycle time: figure in ms, clock in kHz, cycles derived
`define SRS_WR_TIME_MS     5
`define SRS_CLK_KHZ        125000
`define SRS_WR_CYCLES      (`SRS_WR_TIME_MS * `SRS_CLK_KHZ)
`define SRS_WR_CNT_W       20

`endif

//--- pkg/srs_pkg.sv
package srs_pkg;

  // bus-side sequencer states
  typedef enum logic [2:0] {
    SRS_IDLE,
    SRS_DEV,
    SRS_DEV_ACK,
    SRS_WADDR,
    SRS_WADDR_ACK,
    SRS_TX,
    SRS_TX_ACK,
    SRS_WAIT
  } srs_state_e;

  typedef logic [7:0] srs_byte_t;

endpackage

//--- test/serial_eeprom_read_sequencer_bench.sv
`timescale 1ns/1ns
`define SRB_CHECK(what, expv, gotv) \
  begin \
    checks++; \
    if ((gotv) !== (expv)) begin \
      n_fail++; \
      $display("Error %s expected %0h seen %0h", what, expv, gotv); \
    end \
  end

module serial_eeprom_read_sequencer_bench;
  localparam int WRC = 400; // shortened write cycle

  logic       clk_in          = 1'h0;
  logic       rst_n_in        = 1'h0;
  logic       strap           = 1'h0;
  logic       mem_valid_in    = 1'h0;
  logic [7:0] mem_data_in     = 8'h00;
  logic       addr_set_in     = 1'h0;
  logic [9:0] addr_set_val_in = 10'h000;
  logic       write_stop_in   = 1'h0;
  logic       sda_out, sda_oe_out, mem_rd_out, busy_out, scl, m_oe, res_v;
  logic [9:0] mem_addr_out, pa, va;
  logic [8:0] res, exp_n;
  logic [7:0] mem [0:1023];
  logic [8:0] exp_q [$];
  logic       pend = 1'h0;
  int         lat, cnt;
  int         n_fail = 0;
  int         checks = 0;
  wire        sda_w = (sda_oe_out === 1'h1 ? sda_out : 1'h1) & ~m_oe; // pull-up when nobody drives

  always #4 clk_in = ~clk_in;

  srs_read_seq #(.WR_CYCLES(WRC)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .chip_select_strap_in(strap), .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out), .mem_data_in(mem_data_in), .mem_valid_in(mem_valid_in),
    .addr_set_in(addr_set_in), .addr_set_val_in(addr_set_val_in), .write_stop_in(write_stop_in),
    .busy_out(busy_out)
  );

  srs_master m (
    .clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_oe_out(m_oe), .res_v_out(res_v), .res_out(res)
  );

  // array model: random latency, garbage on the data lines when not answering
  always @(negedge clk_in) begin
    mem_valid_in = 1'h0;
    mem_data_in  = 8'($urandom);
    if (pend && lat == 0) begin
      mem_valid_in = 1'h1;
      mem_data_in  = mem[pa];
      pend         = 1'h0;
    end else if (pend) begin
      lat--;
    end
    if (mem_rd_out === 1'h1) begin
      pend = 1'h1;
      lat  = $urandom_range(2, 0);
      pa   = mem_addr_out;
    end
    if (!rst_n_in) begin
      pend = 1'h0;
    end
  end

  // monitor: each bus result is matched against the oldest note
  always @(posedge clk_in) begin
    if (res_v === 1'h1) begin
      if (exp_q.size() > 0) begin
        exp_n = exp_q.pop_front();
      end else begin
        exp_n = 9'h1FF;
      end
      `SRB_CHECK("bus result", exp_n, res)
    end
  end

  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // written byte; notes whether the slave should ack
  task automatic wb(input logic [7:0] b, input logic ackd);
    exp_q.push_back({1'h1, 7'h00, ~ackd});
    m.wr_byte(b);
  endtask

  task automatic dev(input logic [3:0] ty, input logic st, input logic [1:0] pg, input logic rw, input logic ackd);
    m.start();
    wb({ty, st, pg, rw}, ackd);
  endtask

  // n sequential bytes from a, last one nacked, then stop
  task automatic rd_run(input logic [9:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({1'h0, mem[10'(a + i)]});
      m.rd_byte(i == n - 1);
    end
    m.stop();
    `SRB_CHECK("data line released", 1'h0, sda_oe_out)
  endtask

  // main sequence
  initial begin
    void'($urandom(59926));
    foreach (mem[i]) begin
      mem[i] = 8'($urandom);
    end
    strap = 1'($urandom);
    repeat (4) @(negedge clk_in);
    `SRB_CHECK("reset outputs", 3'h0, {sda_oe_out, busy_out, mem_rd_out})
    rst_n_in = 1'h1;
    repeat (4) @(negedge clk_in);
    // single current read from the reset address
    dev(4'hA, strap, 2'h0, 1'h1, 1'h1);
    rd_run(10'h000, 1);
    // sequential read carries on from last plus one
    dev(4'hA, strap, 2'h0, 1'h1, 1'h1);
    rd_run(10'h001, 3);
    // random read via dummy write, running over the top of the array
    dev(4'hA, strap, 2'h3, 1'h0, 1'h1);
    wb(8'hFE, 1'h1);
    dev(4'hA, strap, 2'h3, 1'h1, 1'h1);
    rd_run(10'h3FE, 4);
    // wrong strap and wrong type code are not acked and leave the address
    dev(4'hA, ~strap, 2'h0, 1'h1, 1'h0);
    m.stop();
    dev(4'h5, strap, 2'h0, 1'h1, 1'h0);
    m.stop();
    dev(4'hA, strap, 2'h0, 1'h1, 1'h1);
    rd_run(10'h002, 1);
    // word address loaded by the write side
    va = 10'($urandom);
    @(negedge clk_in);
    addr_set_val_in = va;
    addr_set_in     = 1'h1;
    @(negedge clk_in);
    addr_set_in = 1'h0;
    dev(4'hA, strap, va[9:8], 1'h1, 1'h1);
    rd_run(va, 2);
    va = 10'(va + 2);
    // write cycle: bus ignored while busy, then served again
    @(negedge clk_in);
    write_stop_in = 1'h1;
    @(negedge clk_in);
    write_stop_in = 1'h0;
    fork
      begin
        for (int k = 0; k < 8 && busy_out !== 1'h1; k++) begin
          @(negedge clk_in);
        end
        cnt = 0;
        while (busy_out === 1'h1 && cnt < 2000) begin
          cnt++;
          @(negedge clk_in);
        end
      end
      begin
        dev(4'hA, strap, va[9:8], 1'h1, 1'h0);
        m.stop();
      end
    join
    `SRB_CHECK("write cycle length", WRC, cnt)
    if (cnt >= 2000) begin
      close_out();
    end
    dev(4'hA, strap, va[9:8], 1'h1, 1'h1);
    rd_run(va, 1);
    repeat (4) @(negedge clk_in);
    `SRB_CHECK("pending results", 0, exp_q.size())
    close_out();
  end
endmodule

//--- test/srs_master.sv
`timescale 1ns/1ns
// two-wire bus master model; open drain on data, drives the bus clock
module srs_master (
  input  wire logic       clk_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            sda_oe_out,
  output logic            res_v_out,
  output logic [8:0]      res_out
);
  localparam int HP = 4; // phase step in clocks (low phase two steps, high phase one), above the 2 clock minimum

  // idle bus: clock high, data released
  initial begin
    scl_out    = 1'h1;
    sda_oe_out = 1'h0;
    res_v_out  = 1'h0;
    res_out    = 9'h000;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // one cycle result pulse for the bench monitor
  task automatic report(input logic [8:0] v);
    res_out   = v;
    res_v_out = 1'h1;
    tick(1);
    res_v_out = 1'h0;
  endtask

  // data changes mid low phase, so it never moves while the clock is high
  task automatic bit_io(input logic b, output logic s);
    tick(HP);
    sda_oe_out = ~b;
    tick(HP);
    scl_out = 1'h1;
    tick(HP);
    s       = sda_in;
    scl_out = 1'h0;
  endtask

  // also serves as repeated start from a low clock
  task automatic start();
    sda_oe_out = 1'h0;
    tick(HP);
    scl_out = 1'h1;
    tick(HP);
    sda_oe_out = 1'h1;
    tick(HP);
    scl_out = 1'h0;
  endtask

  task automatic stop();
    tick(HP);
    sda_oe_out = 1'h1;
    tick(HP);
    scl_out = 1'h1;
    tick(HP);
    sda_oe_out = 1'h0;
    tick(HP);
  endtask

  // msb first, then release for the slave's ack slot
  task automatic wr_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'h1, s);
    report({1'h1, 7'h00, s});
  endtask

  // nack high ends the read, low keeps it going
  task automatic rd_byte(input logic nack);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, s);
      v[i] = s;
    end
    bit_io(nack, s);
    report({1'h0, v});
  endtask
endmodule
